// [design/etws_regs.svh]
// offsets, field positions, reset values and timing counts of the two-wire slave front end
`ifndef ETWS_REGS_SVH
`define ETWS_REGS_SVH

// system clock rate and input noise suppression window
`define ETWS_CLK_MHZ        200
`define ETWS_NOISE_NS       50
`define ETWS_NOISE_CYC      ((`ETWS_NOISE_NS * `ETWS_CLK_MHZ) / 1000)

// byte framing: eight data clocks and one acknowledge clock
`define ETWS_DATA_BITS      4'h8
`define ETWS_ACK_CLOCK      4'h9

// device address byte fields
`define ETWS_DA_TYPE_HI     7
`define ETWS_DA_TYPE_LO     4
`define ETWS_DA_SEL_HI      3
`define ETWS_DA_SEL_LO      1
`define ETWS_DA_RW          0

// word address and array shape
`define ETWS_ADDR_W         16
`define ETWS_PAGE_COUNT     512
`define ETWS_PAGE_BYTES     128
`define ETWS_PAGE_OFS_W     7
`define ETWS_PAGE_IDX_W     9

// reset values
`define ETWS_LINE_IDLE      1'b1
`define ETWS_SDA_RELEASED   1'b0
`define ETWS_ADDR_RESET     16'h0000

`endif

// [design/etws_pkg.sv]
// types shared by the two-wire slave front end
package etws_pkg;

   typedef enum logic [6:0] {
      ETWS_STANDBY = 7'h01,
      ETWS_DEVADDR = 7'h02,
      ETWS_ADDR_HI = 7'h04,
      ETWS_ADDR_LO = 7'h08,
      ETWS_RX_DATA = 7'h10,
      ETWS_TX_DATA = 7'h20,
      ETWS_IGNORE  = 7'h40
   } etws_state_t;

endpackage

// [design/etws_glitch_filter.sv]
// two-flop synchroniser followed by a stability filter for one bus line
`timescale 1ns/100ps
`include "etws_regs.svh"

module etws_glitch_filter #(
   parameter int          HOLD_CYC = `ETWS_NOISE_CYC
) (
   // clock and reset
   input  wire logic      clock,
   input  wire logic      rstn,
   // line
   input  wire logic      pinIn,
   output logic           filtered
);

   logic       syncA;
   logic       syncB;
   logic [7:0] stableCnt;
   logic [7:0] next_stableCnt;
   logic       next_filtered;

   // a new level is taken only after it outlasts the noise window
   always_comb begin
      next_stableCnt = 8'h00;
      next_filtered  = filtered;
      if (syncB != filtered) begin
         if (stableCnt >= 8'(HOLD_CYC)) begin
            next_filtered = syncB;
         end else begin
            next_stableCnt = stableCnt + 8'h01;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         syncA     <= `ETWS_LINE_IDLE;
         syncB     <= `ETWS_LINE_IDLE;
         stableCnt <= 8'h00;
         filtered  <= `ETWS_LINE_IDLE;
      end else begin
         syncA     <= pinIn;
         syncB     <= syncA;
         stableCnt <= next_stableCnt;
         filtered  <= next_filtered;
      end
   end

endmodule

// [design/etws_link_capture.sv]
// samples the data line on each rising edge of the serial clock
`timescale 1ns/100ps

module etws_link_capture (
   // link clock and reset
   input  wire logic      sclClk,
   input  wire logic      rstn,
   // line
   input  wire logic      sdaIn,
   // captured bit, toggle marks each new one
   output logic           bitVal,
   output logic           bitToggle
);

   logic next_bitVal;
   logic next_bitToggle;

   always_comb begin
      next_bitVal    = sdaIn;
      next_bitToggle = ~bitToggle;
   end

   always_ff @(posedge sclClk or negedge rstn) begin
      if (!rstn) begin
         bitVal    <= 1'b1;
         bitToggle <= 1'b0;
      end else begin
         bitVal    <= next_bitVal;
         bitToggle <= next_bitToggle;
      end
   end

endmodule

// [design/etws_slave_front.sv]
// two-wire slave front end: framing, addressing and acknowledge of a byte-wide memory
`timescale 1ns/100ps
`include "etws_regs.svh"

module etws_slave_front #(
   parameter logic [3:0]  DEV_TYPE_ID = 4'h5, // arbitrary type code
   parameter int          NOISE_CYC   = `ETWS_NOISE_CYC
) (
   // system clock and reset
   input  wire logic                               clock,
   input  wire logic                               rstn,
   // serial clock as link clock
   input  wire logic                               sclClk,
   // bus pins
   input  wire logic                               sclIn,
   input  wire logic                               sdaIn,
   output logic                                    sdaOut,
   output logic                                    sdaOe,
   // hardwired select pins
   input  wire logic                               select_pin_high,
   input  wire logic                               select_pin_mid,
   input  wire logic                               select_pin_low,
   // array side
   input  wire logic                               writeBusy,
   input  wire logic [7:0]                         rdData,
   output logic [`ETWS_ADDR_W-1:0]                 wordAddr,
   output logic [`ETWS_PAGE_IDX_W-1:0]             pageIndex,
   output logic [`ETWS_PAGE_OFS_W-1:0]             pageOffset,
   output logic [7:0]                              wrData,
   output logic                                    wrStrobe,
   output logic                                    rdTake,
   output logic                                    stopCommit,
   // status
   output logic                                    standby,
   output logic                                    busIdle,
   output logic                                    readMode,
   output logic                                    selected
);
   import etws_pkg::*;

   etws_state_t  state;
   etws_state_t  next_state;
   logic         sclF;
   logic         sdaF;
   logic         sclP;
   logic         sdaP;
   logic         linkBit;
   logic         linkTog;
   logic         togA;
   logic         togB;
   logic         togC;
   logic [2:0]   selA;
   logic [2:0]   selB;
   logic         startEv;
   logic         stopEv;
   logic         sclFall;
   logic         bitEv;
   logic [3:0]   bitCnt;
   logic [3:0]   next_bitCnt;
   logic [7:0]   rxSh;
   logic [7:0]   next_rxSh;
   logic [7:0]   txSh;
   logic [7:0]   next_txSh;
   logic         sdaDrive;
   logic         next_sdaDrive;
   logic         masterAck;
   logic         next_masterAck;
   logic         gotData;
   logic         next_gotData;
   logic [`ETWS_ADDR_W-1:0] next_wordAddr;
   logic [7:0]   next_wrData;
   logic         next_wrStrobe;
   logic         next_rdTake;
   logic         next_stopCommit;
   logic         next_readMode;
   logic         next_selected;

   // device address match on type code and select pins
   function automatic logic addrMatch(input logic [7:0] da, input logic [2:0] sel);
      addrMatch = (da[`ETWS_DA_TYPE_HI:`ETWS_DA_TYPE_LO] == DEV_TYPE_ID)
                  && (da[`ETWS_DA_SEL_HI:`ETWS_DA_SEL_LO] == sel);
   endfunction

   etws_glitch_filter #(
      .HOLD_CYC (NOISE_CYC)
   ) u_sclFilter (
      .clock    (clock),
      .rstn     (rstn),
      .pinIn    (sclIn),
      .filtered (sclF)
   );

   etws_glitch_filter #(
      .HOLD_CYC (NOISE_CYC)
   ) u_sdaFilter (
      .clock    (clock),
      .rstn     (rstn),
      .pinIn    (sdaIn),
      .filtered (sdaF)
   );

   etws_link_capture u_capture (
      .sclClk    (sclClk),
      .rstn      (rstn),
      .sdaIn     (sdaIn),
      .bitVal    (linkBit),
      .bitToggle (linkTog)
   );

   // line changes while clock high are framing, not data
   assign startEv = sclF & sclP & sdaP & ~sdaF;
   assign stopEv  = sclF & sclP & ~sdaP & sdaF;
   assign sclFall = sclP & ~sclF;
   // captured bit is held until the next rising edge, long after the toggle lands
   assign bitEv   = togB ^ togC;

   // open drain: the pin is only ever pulled low
   assign sdaOut  = 1'b0;
   assign sdaOe   = sdaDrive;

   assign busIdle = sclF & sdaF;

   // page and offset split of the word address
   assign pageIndex  = wordAddr[`ETWS_ADDR_W-1:`ETWS_PAGE_OFS_W];
   assign pageOffset = wordAddr[`ETWS_PAGE_OFS_W-1:0];

   // standby when no transfer and no write cycle running
   assign standby = (state == ETWS_STANDBY) & ~writeBusy;

   always_comb begin
      next_state      = state;
      next_bitCnt     = bitCnt;
      next_rxSh       = rxSh;
      next_txSh       = txSh;
      next_sdaDrive   = sdaDrive;
      next_masterAck  = masterAck;
      next_gotData    = gotData;
      next_wordAddr   = wordAddr;
      next_wrData     = wrData;
      next_wrStrobe   = 1'b0;
      next_rdTake     = 1'b0;
      next_stopCommit = 1'b0;
      next_readMode   = readMode;
      next_selected   = selected;

      if (startEv) begin
         // leave standby and expect a device address
         next_state    = ETWS_DEVADDR;
         next_bitCnt   = 4'h0;
         next_sdaDrive = `ETWS_SDA_RELEASED;
         next_gotData  = 1'b0;
         next_selected = 1'b0;
      end else if (stopEv) begin
         next_stopCommit = (state == ETWS_RX_DATA) & gotData;
         next_state      = ETWS_STANDBY;
         next_bitCnt     = 4'h0;
         next_sdaDrive   = `ETWS_SDA_RELEASED;
         next_selected   = 1'b0;
         next_gotData    = 1'b0;
      end else begin
         case (state)
            // nothing but a start is seen here
            ETWS_STANDBY: begin
               next_sdaDrive = `ETWS_SDA_RELEASED;
            end
            // stay off the line until next start
            ETWS_IGNORE: begin
               next_sdaDrive = `ETWS_SDA_RELEASED;
            end
            default: begin
               if (bitEv) begin
                  // every clock counts, no idle slots within a byte
                  if (bitCnt < `ETWS_DATA_BITS) begin
                     next_rxSh   = {rxSh[6:0], linkBit};
                     next_bitCnt = bitCnt + 4'h1;
                  end else if (bitCnt == `ETWS_DATA_BITS) begin
                     next_bitCnt = `ETWS_ACK_CLOCK;
                     // high in ninth clock is not-acknowledge
                     if (state == ETWS_TX_DATA) begin
                        next_masterAck = ~linkBit;
                     end
                  end
               end else if (sclFall) begin
                  if (bitCnt == `ETWS_DATA_BITS) begin
                     // ack slot opens at end of eighth bit
                     case (state)
                        ETWS_DEVADDR: begin
                           // never while a write cycle runs
                           if (addrMatch(rxSh, selB) && !writeBusy) begin
                              next_sdaDrive = 1'b1;
                              next_selected = 1'b1;
                              next_readMode = rxSh[`ETWS_DA_RW];
                           end else begin
                              next_sdaDrive = `ETWS_SDA_RELEASED;
                              next_state    = ETWS_IGNORE;
                              next_bitCnt   = 4'h0;
                           end
                        end
                        // each word address byte is acknowledged
                        ETWS_ADDR_HI: begin
                           next_sdaDrive                = 1'b1;
                           next_wordAddr[15:8]          = rxSh;
                        end
                        ETWS_ADDR_LO: begin
                           next_sdaDrive                = 1'b1;
                           next_wordAddr[7:0]           = rxSh;
                        end
                        ETWS_RX_DATA: begin
                           next_sdaDrive = 1'b1;
                           next_wrData   = rxSh;
                           next_wrStrobe = 1'b1;
                           next_gotData  = 1'b1;
                        end
                        ETWS_TX_DATA: begin
                           // sender lets go for the master's answer
                           next_sdaDrive = `ETWS_SDA_RELEASED;
                        end
                        default: begin
                           next_sdaDrive = `ETWS_SDA_RELEASED;
                        end
                     endcase
                  end else if (bitCnt == `ETWS_ACK_CLOCK) begin
                     // release at end of ninth clock
                     next_sdaDrive = `ETWS_SDA_RELEASED;
                     next_bitCnt   = 4'h0;
                     case (state)
                        ETWS_DEVADDR: begin
                           if (readMode) begin
                              // current address read starts straight away
                              next_state    = ETWS_TX_DATA;
                              next_sdaDrive = ~rdData[7];
                              next_txSh     = {rdData[6:0], 1'b0};
                              next_rdTake   = 1'b1;
                           end else begin
                              // word address bytes follow a write address
                              next_state = ETWS_ADDR_HI;
                           end
                        end
                        ETWS_ADDR_HI: begin
                           next_state = ETWS_ADDR_LO;
                        end
                        ETWS_ADDR_LO: begin
                           next_state = ETWS_RX_DATA;
                        end
                        ETWS_RX_DATA: begin
                           next_state = ETWS_RX_DATA;
                        end
                        ETWS_TX_DATA: begin
                           if (masterAck) begin
                              next_sdaDrive = ~rdData[7];
                              next_txSh     = {rdData[6:0], 1'b0};
                              next_rdTake   = 1'b1;
                           end else begin
                              // recovery clocks always reach this release
                              next_state = ETWS_IGNORE;
                           end
                        end
                        default: begin
                           next_state = ETWS_IGNORE;
                        end
                     endcase
                  end else if ((state == ETWS_TX_DATA) && (bitCnt != 4'h0)) begin
                     // next bit driven on falling edge
                     next_sdaDrive = ~txSh[7];
                     next_txSh     = {txSh[6:0], 1'b0};
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state      <= ETWS_STANDBY;
         sclP       <= `ETWS_LINE_IDLE;
         sdaP       <= `ETWS_LINE_IDLE;
         togA       <= 1'b0;
         togB       <= 1'b0;
         togC       <= 1'b0;
         selA       <= 3'h0;
         selB       <= 3'h0;
         bitCnt     <= 4'h0;
         rxSh       <= 8'h00;
         txSh       <= 8'h00;
         sdaDrive   <= `ETWS_SDA_RELEASED;
         masterAck  <= 1'b0;
         gotData    <= 1'b0;
         wordAddr   <= `ETWS_ADDR_RESET;
         wrData     <= 8'h00;
         wrStrobe   <= 1'b0;
         rdTake     <= 1'b0;
         stopCommit <= 1'b0;
         readMode   <= 1'b0;
         selected   <= 1'b0;
      end else begin
         state      <= next_state;
         sclP       <= sclF;
         sdaP       <= sdaF;
         togA       <= linkTog;
         togB       <= togA;
         togC       <= togB;
         selA       <= {select_pin_high, select_pin_mid, select_pin_low};
         selB       <= selA;
         bitCnt     <= next_bitCnt;
         rxSh       <= next_rxSh;
         txSh       <= next_txSh;
         sdaDrive   <= next_sdaDrive;
         masterAck  <= next_masterAck;
         gotData    <= next_gotData;
         wordAddr   <= next_wordAddr;
         wrData     <= next_wrData;
         wrStrobe   <= next_wrStrobe;
         rdTake     <= next_rdTake;
         stopCommit <= next_stopCommit;
         readMode   <= next_readMode;
         selected   <= next_selected;
      end
   end

endmodule

// [bench/etws_chk.sv]
// concurrent checks on the ports of the two-wire slave front end
`timescale 1ns/100ps

module etws_chk (
   // system clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // bus pins
   input  wire logic        sclIn,
   input  wire logic        sdaIn,
   input  wire logic        sdaOut,
   input  wire logic        sdaOe,
   // array side and status
   input  wire logic        writeBusy,
   input  wire logic [15:0] wordAddr,
   input  wire logic [8:0]  pageIndex,
   input  wire logic [6:0]  pageOffset,
   input  wire logic        wrStrobe,
   input  wire logic        rdTake,
   input  wire logic        standby,
   input  wire logic        busIdle,
   input  wire logic        readMode,
   input  wire logic        selected
);
   logic [7:0] runLow;
   logic [7:0] runHigh;
   logic [7:0] next_runLow;
   logic [7:0] next_runHigh;

   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   // saturating run lengths of both lines high and of either line low
   always_comb begin
      next_runLow  = (sclIn && sdaIn) ? 8'h00 : (runLow == 8'hff ? runLow : runLow + 8'h01);
      next_runHigh = !(sclIn && sdaIn) ? 8'h00 : (runHigh == 8'hff ? runHigh : runHigh + 8'h01);
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         runLow  <= 8'h00;
         runHigh <= 8'h00;
      end else begin
         runLow  <= next_runLow;
         runHigh <= next_runHigh;
      end
   end

   page_split_a: assert property (pageIndex == wordAddr[15:7] && pageOffset == wordAddr[6:0])
      else $error("page split differs from word address");
   drive_low_a: assert property (sdaOe |-> sdaOut == 1'b0)
      else $error("data line driven high");
   oe_edge_a: assert property ($changed(sdaOe) |-> !sclIn)
      else $error("data drive changed while clock high");
   strobe_once_a: assert property (wrStrobe |=> !wrStrobe)
      else $error("write strobe longer than one cycle");
   take_once_a: assert property (rdTake |=> !rdTake)
      else $error("read take longer than one cycle");
   strobe_ack_a: assert property (wrStrobe |-> $rose(sdaOe))
      else $error("data byte strobe without acknowledge");
   take_read_a: assert property (rdTake |-> readMode && selected)
      else $error("read data taken outside a read");
   busy_standby_a: assert property (writeBusy |-> !standby)
      else $error("standby during write cycle");
   idle_high_a: assert property (runHigh >= 8'h14 |-> busIdle)
      else $error("idle missing with both lines high");
   idle_low_a: assert property (runLow >= 8'h14 |-> !busIdle)
      else $error("idle shown with a line low");
   stop_rest_a: assert property (runHigh >= 8'h78 |-> !selected && !sdaOe && (standby || writeBusy))
      else $error("device active on an idle bus");
endmodule

// [bench/etws_master.sv]
// two-wire bus master model driving the serial clock and the data line
`timescale 1ns/100ps

module etws_master #(
   parameter int          Q = 156
) (
   // bus lines
   output logic           scl,
   output logic           mstOe,
   input  wire logic      sda
);
   initial begin
      scl   = 1'b1;
      mstOe = 1'b0;
   end

   task automatic start();
      mstOe = 1'b0;
      #Q scl = 1'b1;
      #Q mstOe = 1'b1;
      #Q scl = 1'b0;
      #Q;
   endtask

   task automatic stop();
      mstOe = 1'b1;
      #Q scl = 1'b1;
      #Q mstOe = 1'b0;
      #Q;
   endtask

   // one clock, data set while low, sampled mid high
   task automatic clk1(input logic d, output logic q);
      mstOe = ~d;
      #Q scl = 1'b1;
      #Q q = sda;
      #Q scl = 1'b0;
      #Q;
   endtask

   // nine clocks, msb first, no gaps
   task automatic byte9(input logic [8:0] d, output logic [8:0] q);
      logic b;
      for (int i = 8; i >= 0; i--) begin
         clk1(d[i], b);
         q[i] = b;
      end
   endtask
endmodule

// [bench/etws_slave_front_bench.sv]
// self-checking bench of the two-wire slave front end
`timescale 1ns/100ps

module etws_slave_front_bench;
   // quarter serial bit: 156 ns, 31.2 periods of the 5 ns system clock
   localparam int         Q     = 156;
   // arbitrary type code
   localparam logic [3:0] DEVID = 4'h5;
   localparam logic [2:0] SEL   = 3'h6;
   logic        clock, rstn, scl, mstOe, sda, sdaOut, sdaOe, writeBusy, b;
   logic        wrStrobe, rdTake, stopCommit, standby, busIdle, readMode, selected;
   logic [7:0]  rdData, wrData;
   logic [15:0] wordAddr;
   logic [8:0]  pageIndex, q;
   logic [6:0]  pageOffset;
   // select pin levels, moved in mid-run to prove the pin order
   logic [2:0]  sel;
   logic [7:0]  wd [3] = '{8'ha5, 8'h5a, 8'hff};
   logic [7:0]  bad [4] = '{8'h02, 8'h04, 8'h08, 8'h80};
   int          miscompares = 0, tests_run = 0, nStrobe = 0, nCommit = 0, n;

   assign sda = ~(mstOe | (sdaOe & ~sdaOut));

   etws_slave_front #(.DEV_TYPE_ID(DEVID)) i_dut (
      .clock(clock), .rstn(rstn), .sclClk(scl), .sclIn(scl), .sdaIn(sda),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .select_pin_high(sel[2]), .select_pin_mid(sel[1]),
      .select_pin_low(sel[0]), .writeBusy(writeBusy), .rdData(rdData), .wordAddr(wordAddr),
      .pageIndex(pageIndex), .pageOffset(pageOffset), .wrData(wrData), .wrStrobe(wrStrobe),
      .rdTake(rdTake), .stopCommit(stopCommit), .standby(standby), .busIdle(busIdle),
      .readMode(readMode), .selected(selected));
   etws_master #(.Q(Q)) i_mst (.scl(scl), .mstOe(mstOe), .sda(sda));

   initial clock = 1'b0;
   always #2.5 clock = ~clock;

   // array side: next byte offered after each take, pulses counted
   always @(posedge clock) begin
      if (rdTake === 1'b1)
         rdData <= #1 ~rdData;
      if (wrStrobe === 1'b1)
         nStrobe++;
      if (stopCommit === 1'b1)
         nCommit++;
   end

   task automatic chkv(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic send(input logic [7:0] d, input logic [15:0] ack, input string name);
      logic [8:0] r;
      i_mst.byte9({d, 1'b1}, r);
      chkv(name, ack, {15'h0000, r[0]});
   endtask

   function automatic logic [7:0] dev(input logic [2:0] s, input logic rw);
      return {DEVID, s, rw};
   endfunction

   task automatic idle();
      repeat (200) @(posedge clock);
      #1;
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #400000;
      miscompares++;
      give_verdict();
   end

   initial begin
      rstn = 1'b0;
      writeBusy = 1'b0;
      sel = SEL;
      rdData = 8'h6d;
      repeat (3) @(posedge clock);
      #1 rstn = 1'b1;
      idle();
      chkv("rst standby", 1, standby);
      chkv("rst oe", 0, sdaOe);
      chkv("rst addr", 0, wordAddr);
      i_mst.start();
      chkv("awake", 0, standby);
      send(dev(SEL, 1'b0), 0, "addr ack");
      chkv("selected", 1, selected);
      send(8'h9c, 0, "hi ack");
      send(8'h3b, 0, "lo ack");
      chkv("word", 16'h9c3b, wordAddr);
      chkv("page", 16'h0138, {7'h00, pageIndex});
      chkv("offset", 16'h003b, {9'h000, pageOffset});
      foreach (wd[i]) begin
         send(wd[i], 0, "data ack");
         chkv("data", {8'h00, wd[i]}, {8'h00, wrData});
      end
      i_mst.stop();
      idle();
      chkv("strobes", 3, nStrobe[15:0]);
      chkv("commit", 1, nCommit[15:0]);
      chkv("standby", 1, standby);
      chkv("idle", 1, busIdle);
      $display("test write done");
      foreach (bad[i]) begin
         i_mst.start();
         send(dev(SEL, 1'b0) ^ bad[i], 1, "decline");
         send(8'h00, 1, "ignored");
         chkv("unselected", 0, selected);
         i_mst.stop();
      end
      // new pin levels: the matching address must follow the pins, high to low
      @(posedge clock) #1 sel = 3'h3;
      i_mst.start();
      send(dev(3'h3, 1'b0), 0, "pins moved");
      i_mst.stop();
      i_mst.start();
      send(dev(SEL, 1'b0), 1, "old pins");
      i_mst.stop();
      @(posedge clock) #1 sel = SEL;
      idle();
      chkv("no strobe", 3, nStrobe[15:0]);
      $display("test decline done");
      @(posedge clock) #1 writeBusy = 1'b1;
      i_mst.start();
      send(dev(SEL, 1'b0), 1, "busy nack");
      chkv("busy standby", 0, standby);
      i_mst.stop();
      @(posedge clock) #1 writeBusy = 1'b0;
      $display("test busy done");
      idle();
      i_mst.start();
      send(dev(SEL, 1'b0), 0, "ready ack");
      send(8'h01, 0, "hi ack");
      send(8'h80, 0, "lo ack");
      i_mst.start();
      send(dev(SEL, 1'b1), 0, "read ack");
      chkv("read mode", 1, readMode);
      i_mst.byte9(9'h1fe, q);
      chkv("rd byte", 16'h006d, {8'h00, q[8:1]});
      i_mst.byte9(9'h1ff, q);
      chkv("rd byte", 16'h0092, {8'h00, q[8:1]});
      chkv("released", 0, sdaOe);
      i_mst.stop();
      idle();
      chkv("read commit", 1, nCommit[15:0]);
      $display("test read done");
      @(posedge clock) #1 rdData = 8'h00;
      i_mst.start();
      send(dev(SEL, 1'b1), 0, "read ack");
      n = 0;
      do begin
         i_mst.clk1(1'b1, b);
         n++;
      end while (b !== 1'b1 && n < 12);
      chkv("recovery clocks", 9, n[15:0]);
      i_mst.start();
      send(dev(SEL, 1'b0), 0, "after recovery");
      chkv("write mode", 0, readMode);
      i_mst.stop();
      idle();
      $display("test recovery done");
      give_verdict();
   end
endmodule

bind etws_slave_front etws_chk i_chk (.*);
